// File: src/otb_bridge.sv
// Purpose: Memory-mapped slave to shared off-chip tristate bus bridge
// Assumes: Devices are decoded by base and size; one access at a time
// Notes:   All pin outputs are flops; data in optionally registered
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - One shared pin set, one device at a time
// - Path for devices with bidirectional data
// - Path for devices sharing address or data
// - Build option registers every incoming pin
// - Unregistered option passes read data straight
// - Every outgoing pin is always registered
// - Each register stage adds one cycle
// - Stages leave setup, wait, hold unchanged
// - Memory-mapped slave port for on-chip masters
// - Tristate master port toward external memories
// - Bridge clock sets external bus cycle time
// - Addresses pass unchanged; each device has base
// - Address bus only as wide as needed
// - Byte address always on external bus
module otb_bridge
    import otb_pkg::*;
#(
    parameter int unsigned AW        = OTB_ADDR_W,
    parameter int unsigned DW        = OTB_DATA_W,
    parameter int unsigned NDEV      = OTB_NDEV,
    parameter bit          REG_IN    = OTB_REG_IN,
    parameter int unsigned SETUP_CYC = OTB_SETUP_CYC,
    parameter int unsigned WAIT_CYC  = OTB_WAIT_CYC,
    parameter int unsigned HOLD_CYC  = OTB_HOLD_CYC,
    parameter logic [NDEV*AW-1:0] DEV_BASE = {24'h80_0000, 24'h00_0000},
    parameter logic [NDEV*AW-1:0] DEV_MASK = {24'h80_0000, 24'h80_0000}
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // On-chip slave side
    input  wire logic [AW-1:0]     s_address,
    input  wire logic              s_read,
    input  wire logic              s_write,
    input  wire logic [DW-1:0]     s_writedata,
    input  wire logic [DW/8-1:0]   s_byteenable,
    output logic      [DW-1:0]     s_readdata,
    output logic                   s_readdatavalid,
    output logic                   s_waitrequest,
    // Off-chip tristate master side
    output logic      [AW-1:0]     t_address,
    output logic      [DW-1:0]     t_data_out,
    output logic                   t_data_oe,
    input  wire logic [DW-1:0]     t_data_in,
    output logic      [NDEV-1:0]   t_select_n,
    output logic                   t_read_n,
    output logic                   t_write_n,
    output logic      [DW/8-1:0]   t_byteenable_n
);
    localparam int unsigned IN_LAT = REG_IN ? 1 : 0;
    // Cycles from the sample point to the read data pulse
    localparam int unsigned LAT_D  = IN_LAT + 1;

    otb_state_t             state;     // Transfer phase
    logic [OTB_CNT_W-1:0]   cnt;       // Cycles left in phase after this one
    logic                   is_read;   // Current transfer is a read
    logic [NDEV-1:0]        hit;       // Address decode result
    logic                   lat_pend;  // Read data still in input stage
    logic                   cap;       // Sample strobe for read data
    logic                   take;      // Request accepted at this edge
    logic                   strobe_on; // Either strobe active at pins
    logic [OTB_CNT_W-1:0]   stb_len;   // Cycles the strobe has stood

    otb_rd_if #(.DW(DW)) rd ();
    assign rd.pin_data = t_data_in;

    otb_in_stage #(.REG_IN(REG_IN), .DW(DW)) u_in (
        .clock   (clock),
        .sys_rst (sys_rst),
        .rd      (rd)
    );

    // Decode each device by its base; bridge itself owns no range
    genvar gi;
    generate
        for (gi = 0; gi < NDEV; gi++) begin : g_dec
            assign hit[gi] = ((s_address & DEV_MASK[gi*AW +: AW]) ==
                              DEV_BASE[gi*AW +: AW]);
        end
    endgenerate

    // Accept only while waitrequest is high: in the one cycle it is low
    // the finished request still stands and must not start again
    assign take = (state == OTB_IDLE) && s_waitrequest
                  && (s_read || s_write);

    // Phase sequencer; one transfer at a time on the shared pins
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= OTB_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                OTB_IDLE: begin
                    // New request only taken while bus is free
                    if (take) begin
                        state <= OTB_SETUP;
                        cnt   <= OTB_CNT_W'(SETUP_CYC - 1);
                    end
                end
                OTB_SETUP: begin
                    // Phase lengths count bridge clocks only
                    if (cnt == '0) begin
                        state <= OTB_WAIT;
                        cnt   <= OTB_CNT_W'(WAIT_CYC - 1);
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                OTB_WAIT: begin
                    if (cnt == '0) begin
                        state <= OTB_HOLD;
                        cnt   <= OTB_CNT_W'(HOLD_CYC - 1);
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                OTB_HOLD: begin
                    if (cnt == '0) begin
                        state <= OTB_DONE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                OTB_DONE: begin
                    // Wait for read data to clear the input stage
                    if (!lat_pend) begin
                        state <= OTB_IDLE;
                    end
                end
                default: begin
                    state <= OTB_IDLE;
                end
            endcase
        end
    end

    // Remember transfer kind at acceptance
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            is_read <= 1'b0;
        end else if (take) begin
            is_read <= s_read;
        end
    end

    // Registered pin outputs; flop delay is shared by all pins so
    // the relative setup, wait and hold seen by the memory is kept
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            t_address      <= '0;
            t_data_out     <= '0;
            t_data_oe      <= 1'b0;
            t_select_n     <= '1;
            t_read_n       <= 1'b1;
            t_write_n      <= 1'b1;
            t_byteenable_n <= '1;
        end else if (take) begin
            // Width AW is set by the largest memory attached
            t_address      <= s_address;
            t_data_out     <= s_writedata;
            t_data_oe      <= s_write && !s_read;
            t_select_n     <= ~hit;
            t_byteenable_n <= ~s_byteenable;
        end else if (state == OTB_SETUP && cnt == '0) begin
            t_read_n  <= ~is_read;
            t_write_n <= is_read;
        end else if (state == OTB_WAIT && cnt == '0) begin
            t_read_n  <= 1'b1;
            t_write_n <= 1'b1;
        end else if (state == OTB_HOLD && cnt == '0) begin
            t_data_oe      <= 1'b0;
            t_select_n     <= '1;
            t_byteenable_n <= '1;
        end
    end

    // Sample point: last wait cycle, strobe still active at pins
    assign cap = (state == OTB_WAIT) && (cnt == '0) && is_read;

    // Track the input stage latency for reads
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lat_pend <= 1'b0;
        end else begin
            lat_pend <= cap && (IN_LAT != 0);
        end
    end

    // Read data back to the fabric, one cycle later if registered
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_readdata      <= '0;
            s_readdatavalid <= 1'b0;
        end else begin
            s_readdatavalid <= (IN_LAT != 0) ? lat_pend : cap;
            if ((IN_LAT != 0) ? lat_pend : cap) begin
                s_readdata <= rd.fab_data;
            end
        end
    end

    // Master held until the transfer is fully done
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_waitrequest <= 1'b1;
        end else begin
            s_waitrequest <= !(state == OTB_DONE && !lat_pend);
        end
    end

    // Strobe length, kept only for the wait-phase check below
    assign strobe_on = !t_read_n || !t_write_n;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stb_len <= '0;
        end else if (strobe_on) begin
            stb_len <= stb_len + 1'b1; // Wait phase is far below 256
        end else begin
            stb_len <= '0;
        end
    end

    // Checks on the pin sequencing and the slave handshake
    sequence s_strobe_run;
        strobe_on;
    endsequence
    sequence s_setup_end;
        ##SETUP_CYC strobe_on;
    endsequence
    sequence s_hold_end;
        ##HOLD_CYC (&t_select_n);
    endsequence
    a_one_select: assert property (
        @(posedge clock) disable iff (sys_rst)
        $countones(~t_select_n) <= 1)
        else $error("more than one device selected");
    a_oe_write: assert property (
        @(posedge clock) disable iff (sys_rst)
        t_data_oe |-> !is_read && (state == OTB_SETUP
        || state == OTB_WAIT || state == OTB_HOLD))
        else $error("data driven outside a write");
    a_no_oe_read: assert property (
        @(posedge clock) disable iff (sys_rst)
        !t_read_n |-> !t_data_oe)
        else $error("data driven during read");
    a_setup_len: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(&t_select_n) |-> s_setup_end)
        else $error("strobe not after setup phase");
    a_wait_len: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(strobe_on) |-> stb_len == OTB_CNT_W'(WAIT_CYC))
        else $error("strobe length differs from wait phase");
    a_hold_len: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(strobe_on) |-> s_hold_end)
        else $error("select not released after hold phase");
    a_strobe_sel: assert property (
        @(posedge clock) disable iff (sys_rst)
        s_strobe_run |-> (t_select_n != '1))
        else $error("strobe without select");
    a_wait_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state != OTB_IDLE) |-> s_waitrequest)
        else $error("waitrequest dropped early");
    a_lat_valid: assert property (
        @(posedge clock) disable iff (sys_rst)
        cap |-> ##LAT_D s_readdatavalid)
        else $error("read latency wrong");
    a_done_rel: assert property (
        @(posedge clock) disable iff (sys_rst)
        (state == OTB_DONE && !lat_pend) |=> !s_waitrequest)
        else $error("waitrequest not released");
    a_no_reaccept: assert property (
        @(posedge clock) disable iff (sys_rst)
        !s_waitrequest |=> (state == OTB_IDLE))
        else $error("finished request taken again");
endmodule
`default_nettype wire

// File: src/otb_pkg.sv
// Purpose: Shared constants for the off-chip tristate memory bridge
// Assumes: One clock at 250 MHz; byte addresses throughout
// Notes:   Device count, widths and timing are parameters at the top
package otb_pkg;
    // Clock period in picoseconds, for deriving cycle counts
    localparam int unsigned OTB_CLK_PS     = 4000;
    // Default external timing per transfer, in nanoseconds
    localparam int unsigned OTB_SETUP_NS   = 8;
    localparam int unsigned OTB_WAIT_NS    = 16;
    localparam int unsigned OTB_HOLD_NS    = 8;
    // Least times round up to whole cycles, never below one
    localparam int unsigned OTB_SETUP_CYC  =
        ((OTB_SETUP_NS * 1000 + OTB_CLK_PS - 1) / OTB_CLK_PS) < 1 ? 1 :
        ((OTB_SETUP_NS * 1000 + OTB_CLK_PS - 1) / OTB_CLK_PS);
    localparam int unsigned OTB_WAIT_CYC   =
        ((OTB_WAIT_NS * 1000 + OTB_CLK_PS - 1) / OTB_CLK_PS) < 1 ? 1 :
        ((OTB_WAIT_NS * 1000 + OTB_CLK_PS - 1) / OTB_CLK_PS);
    localparam int unsigned OTB_HOLD_CYC   =
        ((OTB_HOLD_NS * 1000 + OTB_CLK_PS - 1) / OTB_CLK_PS) < 1 ? 1 :
        ((OTB_HOLD_NS * 1000 + OTB_CLK_PS - 1) / OTB_CLK_PS);
    // Width of the phase counter
    localparam int unsigned OTB_CNT_W      = 8;
    // Default pin widths: address stays below 32 bits
    localparam int unsigned OTB_ADDR_W     = 24;
    localparam int unsigned OTB_DATA_W     = 32;
    localparam int unsigned OTB_NDEV       = 2;
    // Default option: incoming pins registered
    localparam bit          OTB_REG_IN     = 1'b1;

    // Transfer phases, Gray coded along setup, wait, hold
    typedef enum logic [2:0] {
        OTB_IDLE  = 3'b000,
        OTB_SETUP = 3'b001,
        OTB_WAIT  = 3'b011,
        OTB_HOLD  = 3'b010,
        OTB_DONE  = 3'b110
    } otb_state_t;
endpackage

// File: src/otb_rd_if.sv
// Purpose: Carrier for incoming pin data between bridge modules
// Assumes: Same clock on both ends
// Notes:   Source is the input stage, sink is the sequencer
`timescale 1ns/1ps
`default_nettype none
interface otb_rd_if #(parameter int unsigned DW = 32);
    logic [DW-1:0] pin_data; // Raw data from the pins
    logic [DW-1:0] fab_data; // Data as seen by the fabric
    modport stage (input pin_data, output fab_data);
    modport user  (output pin_data, input fab_data);
endinterface
`default_nettype wire

// File: src/otb_in_stage.sv
// Purpose: Optional register stage on data coming in from memories
// Assumes: Pins already meet the clock, timed as a memory interface
// Notes:   Registered setting adds exactly one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module otb_in_stage #(
    parameter bit          REG_IN = 1'b1,
    parameter int unsigned DW     = 32
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    otb_rd_if.stage   rd
);
    generate
        if (REG_IN) begin : g_reg
            logic [DW-1:0] held; // One register per incoming pin
            // Register every incoming data pin
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    held <= '0;
                end else begin
                    held <= rd.pin_data;
                end
            end
            assign rd.fab_data = held;
        end else begin : g_thru
            // Straight path, no register stage
            assign rd.fab_data = rd.pin_data;
        end
    endgenerate
endmodule
`default_nettype wire

// File: verif/otb_mem_model.sv
// Purpose: Word-wide asynchronous memory on the shared tristate pins
// Assumes: 32-bit words, low two address lines ignored
// Notes:   Released data lines show the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module otb_mem_model #(
    parameter int unsigned DEPTH = 256
) (
    input  wire logic        clock,
    input  wire logic        sel_n,
    input  wire logic        read_n,
    input  wire logic        write_n,
    input  wire logic [3:0]  be_n,
    input  wire logic [23:0] addr,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata,
    output logic             drive
);
    logic [31:0] mem [DEPTH]; // Storage words
    logic [31:0] last = '0;   // Last word driven
    logic [7:0]  idx;         // Word index
    // Byte lines below the word size are not wired
    assign idx = addr[9:2];
    // Drive only while selected and read strobe low
    assign drive = !sel_n && !read_n;
    // Inverse of last value keeps a stale bus from passing as data
    assign rdata = drive ? mem[idx] : ~last;
    // Writes land byte by byte under the active-low enables
    always @(posedge clock) begin
        if (drive) begin
            last <= mem[idx];
        end
        if (!sel_n && !write_n) begin
            for (int i = 0; i < 4; i++) begin
                if (!be_n[i]) begin
                    mem[idx][8*i+:8] <= wdata[8*i+:8];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/offchip_tristate_memory_bridge_tb_top.sv
// Purpose: Self-checking bench for the tristate memory bridge
// Assumes: Default 2/4/2 cycle timing; one bridge registered, one not
// Notes:   Two memories share the pins, dev1 in the upper half
`timescale 1ns/1ps
`default_nettype none
`define OTB_CHK(a, e) begin checks++; if ((a) !== (e)) begin \
    num_errors++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module offchip_tristate_memory_bridge_tb_top;
    import otb_pkg::*;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [23:0] s_address = '0;
    logic        s_read = 1'b0;
    logic        s_write = 1'b0;
    logic [31:0] s_writedata = '0;
    logic [3:0]  s_byteenable = '0;
    logic [31:0] s_readdata, t_data_out, d0, d1;
    logic        s_readdatavalid, s_waitrequest, t_data_oe;
    logic [23:0] t_address;
    logic [1:0]  t_select_n;
    logic        t_read_n, t_write_n, dr0, dr1;
    logic [3:0]  t_byteenable_n;
    wire  [31:0] bus;
    // Second bridge without input register, on memories of its own
    logic [31:0] nr_rdata, nr_tdo, d2, d3;
    logic        nr_rdv, nr_wait, nr_oe, nr_rd_n, nr_wr_n, dr2, dr3;
    logic [23:0] nr_addr;
    logic [1:0]  nr_sel_n;
    logic [3:0]  nr_be_n;
    wire  [31:0] nr_bus;
    int          num_errors = 0;
    int          checks = 0;
    int          ticks = 0;
    // Wire level from all drivers of the shared data lines
    assign bus = t_data_oe ? t_data_out : (dr0 ? d0 : d1);
    assign nr_bus = nr_oe ? nr_tdo : (dr2 ? d2 : d3);
    always #2 clock = ~clock;
    otb_bridge dut (.clock(clock), .sys_rst(sys_rst),
        .s_address(s_address), .s_read(s_read), .s_write(s_write),
        .s_writedata(s_writedata), .s_byteenable(s_byteenable),
        .s_readdata(s_readdata), .s_readdatavalid(s_readdatavalid),
        .s_waitrequest(s_waitrequest), .t_address(t_address),
        .t_data_out(t_data_out), .t_data_oe(t_data_oe),
        .t_data_in(bus), .t_select_n(t_select_n), .t_read_n(t_read_n),
        .t_write_n(t_write_n), .t_byteenable_n(t_byteenable_n));
    otb_mem_model m0 (.clock(clock), .sel_n(t_select_n[0]),
        .read_n(t_read_n), .write_n(t_write_n), .be_n(t_byteenable_n),
        .addr(t_address), .wdata(bus), .rdata(d0), .drive(dr0));
    otb_mem_model m1 (.clock(clock), .sel_n(t_select_n[1]),
        .read_n(t_read_n), .write_n(t_write_n), .be_n(t_byteenable_n),
        .addr(t_address), .wdata(bus), .rdata(d1), .drive(dr1));
    // Same stimulus, read data passed straight through
    otb_bridge #(.REG_IN(1'b0)) dut_nr (.clock(clock), .sys_rst(sys_rst),
        .s_address(s_address), .s_read(s_read), .s_write(s_write),
        .s_writedata(s_writedata), .s_byteenable(s_byteenable),
        .s_readdata(nr_rdata), .s_readdatavalid(nr_rdv),
        .s_waitrequest(nr_wait), .t_address(nr_addr),
        .t_data_out(nr_tdo), .t_data_oe(nr_oe),
        .t_data_in(nr_bus), .t_select_n(nr_sel_n), .t_read_n(nr_rd_n),
        .t_write_n(nr_wr_n), .t_byteenable_n(nr_be_n));
    otb_mem_model m2 (.clock(clock), .sel_n(nr_sel_n[0]),
        .read_n(nr_rd_n), .write_n(nr_wr_n), .be_n(nr_be_n),
        .addr(nr_addr), .wdata(nr_bus), .rdata(d2), .drive(dr2));
    otb_mem_model m3 (.clock(clock), .sel_n(nr_sel_n[1]),
        .read_n(nr_rd_n), .write_n(nr_wr_n), .be_n(nr_be_n),
        .addr(nr_addr), .wdata(nr_bus), .rdata(d3), .drive(dr3));
    // One transfer, pins watched every cycle until the master is let go
    task automatic xfer(input logic rd, input logic [23:0] a,
        input logic [31:0] wd, input logic [3:0] be,
        output logic [63:0] rv);
        int          n, bad, sel, strb, rdv, at, at_nr;
        logic        dv;
        logic [31:0] rn;
        dv = a[23];
        at = 0;
        at_nr = 0;
        rn = '0;
        n = 0;
        bad = 0;
        sel = 0;
        strb = 0;
        rdv = 0;
        rv = '0;
        @(negedge clock);
        s_read = rd;
        s_write = !rd;
        s_address = a;
        s_writedata = wd;
        s_byteenable = be;
        do begin
            @(negedge clock);
            n++;
            if (t_select_n !== 2'b11) begin
                sel++;
                if (t_select_n[dv] !== 1'b0 || t_select_n[!dv] !== 1'b1)
                    bad++;
                if (t_address !== a || t_byteenable_n !== ~be)
                    bad++;
            end
            if (rd && t_data_oe !== 1'b0)
                bad++;
            if ((rd ? t_read_n : t_write_n) === 1'b0) begin
                strb++;
                if (!rd && (t_data_oe !== 1'b1 || t_data_out !== wd))
                    bad++;
            end
            if ((rd ? t_write_n : t_read_n) !== 1'b1)
                bad++;
            if (s_readdatavalid === 1'b1) begin
                rdv++;
                at = n;
                rv[31:0] = s_readdata;
            end
            if (nr_rdv === 1'b1) begin
                at_nr = n;
                rn = nr_rdata;
            end
            if (nr_wait !== s_waitrequest)
                bad++;
        end while (s_waitrequest !== 1'b0 && n < 100);
        rv[63:32] = rn;
        `OTB_CHK(at - at_nr, rd ? 1 : 0)
        `OTB_CHK(bad, 0)
        `OTB_CHK(sel > 0, 1'b1)
        `OTB_CHK(strb, OTB_WAIT_CYC)
        `OTB_CHK(rdv, rd ? 1 : 0)
        `OTB_CHK(s_waitrequest, 1'b0)
    endtask
    // Bus goes quiet after the last transfer
    task automatic idle();
        @(negedge clock);
        s_read = 1'b0;
        s_write = 1'b0;
    endtask
    // Outputs at rest while reset holds
    task automatic t_reset();
        repeat (2) @(negedge clock);
        `OTB_CHK({s_waitrequest, s_readdatavalid, t_data_oe}, 3'b100)
        `OTB_CHK({t_select_n, t_read_n, t_write_n, t_byteenable_n}, 8'hFF)
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        $display("reset test done");
    endtask
    // Write then read one word
    task automatic t_basic();
        logic [63:0] r;
        xfer(1'b0, 24'h00_0010, 32'hA5A5_1234, 4'hF, r);
        xfer(1'b1, 24'h00_0010, 32'h0000_0000, 4'hF, r);
        idle();
        `OTB_CHK(r, {2{32'hA5A5_1234}})
        $display("basic test done");
    endtask
    // Same word offset in both devices, back to back
    task automatic t_two_dev();
        logic [63:0] r0, r1;
        xfer(1'b0, 24'h80_0020, 32'h1357_9BDF, 4'hF, r1);
        xfer(1'b0, 24'h00_0020, 32'h2468_ACE0, 4'hF, r0);
        xfer(1'b1, 24'h80_0020, 32'h0000_0000, 4'hF, r1);
        xfer(1'b1, 24'h00_0020, 32'h0000_0000, 4'hF, r0);
        idle();
        `OTB_CHK(r1, {2{32'h1357_9BDF}})
        `OTB_CHK(r0, {2{32'h2468_ACE0}})
        $display("two device test done");
    endtask
    // Partial write, then read at an unaligned byte address
    task automatic t_bytes();
        logic [63:0] r;
        xfer(1'b0, 24'h00_0040, 32'h1111_1111, 4'hF, r);
        xfer(1'b0, 24'h00_0040, 32'hAABB_CCDD, 4'h5, r);
        xfer(1'b1, 24'h00_0042, 32'h0000_0000, 4'hF, r);
        idle();
        `OTB_CHK(r, {2{32'h11BB_11DD}})
        $display("byte test done");
    endtask
    // Counts, verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge clock) begin
        ticks++;
        if (ticks == 5000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        t_reset();
        t_basic();
        t_two_dev();
        t_bytes();
        finish_test();
    end
endmodule
`undef OTB_CHK
`default_nettype wire
